// ===== design/asbc_params.svh
// Purpose: Register map, field positions and reset values of the sequencing control block
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   Included by its bare name
`ifndef ASBC_PARAMS_SVH
`define ASBC_PARAMS_SVH

`define ASBC_OFS_SEQ_CTRL     8'h00
`define ASBC_OFS_CLK_TIMING   8'h04
`define ASBC_OFS_DMA_CTRL     8'h08
`define ASBC_OFS_STATUS       8'h0c

`define ASBC_SEQ_HALF_BIT     7
`define ASBC_SEQ_RATE_LSB     2
`define ASBC_SEQ_RATE_MSB     6
`define ASBC_SEQ_FILL_BIT     1
`define ASBC_SEQ_ALT_BIT      0

`define ASBC_CLK_SRC_BIT      15
`define ASBC_CLK_SAMP_LSB     8
`define ASBC_CLK_SAMP_MSB     12
`define ASBC_CLK_DIV_LSB      0
`define ASBC_CLK_DIV_MSB      7

`define ASBC_DMA_EN_BIT       8

`define ASBC_SEQ_RESET        16'h0000
`define ASBC_CLK_RESET        16'h0000
`define ASBC_DMA_RESET        16'h0000

`endif

// ===== design/asbc_pkg.sv
// Purpose: Types shared by the sequencing control block
// Assumes: Sixteen-entry result buffer, sixteen-bit results
// Notes:   Used with explicit scope, never imported
package asbc_pkg;

   typedef struct packed {
      logic        en;
      logic [3:0]  addr;
      logic [15:0] data;
   } asbc_buf_write_t;

   typedef struct packed {
      logic        clk_src;
      logic [4:0]  samp_time;
      logic [7:0]  clk_div;
   } asbc_clk_cfg_t;

endpackage

// ===== design/asbc_divider.sv
// Purpose: Conversion clock tick from RC oscillator or divided system clock
// Assumes: rc_tick is a one-cycle pulse synchronous to pclk
// Notes:   Tick period is div_value+1 pclk cycles in divider mode
`timescale 1ns/1ps
module asbc_divider #(
   parameter int W = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic         rc_sel,
   input  wire logic         rc_tick,
   input  wire logic [W-1:0] div_value,
   output logic              tick
);
   logic [W-1:0] cnt;
   wire          wrap = (cnt >= div_value);
   wire [W-1:0]  next_cnt = wrap ? '0 : cnt + {{(W-1){1'b0}}, 1'b1};
   wire          next_tick = rc_sel ? rc_tick : wrap;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt  <= '0;
         tick <= 1'b0;
      end
      else if (ce)
      begin
         cnt  <= next_cnt;
         tick <= next_tick;
      end
   end

   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_div_period: assert property (ce && !rc_sel && $past(ce) |=> tick == ($past(cnt) >= $past(div_value)))
      else $error("divider tick out of period");
   a_rc_pass: assert property (ce && rc_sel |=> tick == $past(rc_tick))
      else $error("rc tick not forwarded");
   // Previous cycle must be divider mode, so the tick came from a wrap
   a_div_gap: assert property (ce && !rc_sel && div_value == 8'h01 && tick && $past(ce && !rc_sel)
                               |=> !tick)
      else $error("divide by two ticks too often");
   c_div_tick: cover property (!rc_sel && tick);
endmodule

// ===== design/asbc_ctrl.sv
// Purpose: Converter sequencing, result buffer placement and clock settings
// Assumes: conv_done is a one-cycle pulse per completed sample/conversion
// Notes:   ce low freezes all state, so output pulses stretch while ce is low
`timescale 1ns/1ps
`include "asbc_params.svh"
module asbc_ctrl (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   ce,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   conv_done,
   input  wire logic [15:0]            conv_result,
   input  wire logic                   rc_tick,
   output asbc_pkg::asbc_buf_write_t   buf_wr,
   output logic                        mux_sel_b,
   output logic                        conv_irq,
   output logic                        dma_step,
   output logic                        buffer_half_status,
   output logic                        conv_tick,
   output asbc_pkg::asbc_clk_cfg_t     clk_cfg
);

   logic [4:0] interrupt_increment_rate;
   logic       buffer_fill_mode;
   logic       alternate_sample_mode;
   logic       result_dma_enable;
   logic       conversion_clock_source;
   logic [4:0] auto_sample_time;
   logic [7:0] conversion_clock_divider;
   logic [4:0] op_cnt;
   logic [3:0] wr_idx;

   // Reset images of the writable registers
   localparam logic [15:0] SEQ_RST = `ASBC_SEQ_RESET;
   localparam logic [15:0] CLK_RST = `ASBC_CLK_RESET;
   localparam logic [15:0] DMA_RST = `ASBC_DMA_RESET;

   // APB decode
   wire setup     = psel && !penable;
   wire wr_access = psel && penable && pready && pwrite;
   wire hit_seq   = (paddr == `ASBC_OFS_SEQ_CTRL);
   wire hit_clk   = (paddr == `ASBC_OFS_CLK_TIMING);
   wire hit_dma   = (paddr == `ASBC_OFS_DMA_CTRL);
   wire hit_sts   = (paddr == `ASBC_OFS_STATUS);
   wire mapped    = hit_seq || hit_clk || hit_dma || hit_sts;
   wire ro_write  = hit_sts && pwrite;

   wire [31:0] rd_seq = {24'h000000, buffer_half_status, interrupt_increment_rate,
                         buffer_fill_mode, alternate_sample_mode};
   wire [31:0] rd_clk = {16'h0000, conversion_clock_source, 2'h0, auto_sample_time,
                         conversion_clock_divider};
   wire [31:0] rd_dma = {23'h000000, result_dma_enable, 8'h00};
   wire [31:0] rd_sts = {20'h00000, mux_sel_b, buffer_half_status, wr_idx, 1'b0, op_cnt};
   wire [31:0] next_prdata = hit_seq ? rd_seq :
                             hit_clk ? rd_clk :
                             hit_dma ? rd_dma :
                             hit_sts ? rd_sts : 32'h00000000;

   // Answer one cycle after setup, zero wait otherwise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else if (ce)
      begin
         pready  <= setup;
         pslverr <= setup && (!mapped || ro_write);
         prdata  <= (setup && !pwrite) ? next_prdata : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         interrupt_increment_rate <= SEQ_RST[`ASBC_SEQ_RATE_MSB:`ASBC_SEQ_RATE_LSB];
         buffer_fill_mode         <= SEQ_RST[`ASBC_SEQ_FILL_BIT];
         alternate_sample_mode    <= SEQ_RST[`ASBC_SEQ_ALT_BIT];
      end
      else if (ce && wr_access && hit_seq)
      begin
         interrupt_increment_rate <= pwdata[`ASBC_SEQ_RATE_MSB:`ASBC_SEQ_RATE_LSB];
         buffer_fill_mode         <= pwdata[`ASBC_SEQ_FILL_BIT];
         alternate_sample_mode    <= pwdata[`ASBC_SEQ_ALT_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         conversion_clock_source  <= CLK_RST[`ASBC_CLK_SRC_BIT];
         auto_sample_time         <= CLK_RST[`ASBC_CLK_SAMP_MSB:`ASBC_CLK_SAMP_LSB];
         conversion_clock_divider <= CLK_RST[`ASBC_CLK_DIV_MSB:`ASBC_CLK_DIV_LSB];
      end
      else if (ce && wr_access && hit_clk)
      begin
         conversion_clock_source  <= pwdata[`ASBC_CLK_SRC_BIT];
         auto_sample_time         <= pwdata[`ASBC_CLK_SAMP_MSB:`ASBC_CLK_SAMP_LSB];
         conversion_clock_divider <= pwdata[`ASBC_CLK_DIV_MSB:`ASBC_CLK_DIV_LSB];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         result_dma_enable <= DMA_RST[`ASBC_DMA_EN_BIT];
      else if (ce && wr_access && hit_dma)
         result_dma_enable <= pwdata[`ASBC_DMA_EN_BIT];
   end

   // Sequencing
   // Compare is >= so a rate lowered mid-count ends the run at once
   wire        done      = ce && conv_done;
   wire        cnt_hit   = (op_cnt >= interrupt_increment_rate);
   wire        rate_evt  = done && cnt_hit;
   wire [4:0]  next_op_cnt = cnt_hit ? 5'h00 : op_cnt + 5'h01;
   wire        restart   = rate_evt && !result_dma_enable;
   wire [3:0]  next_wr_idx = restart ? 4'h0 : wr_idx + 4'h1;
   // Half flips only while fill mode holds; otherwise stays on first half
   wire        next_half = !buffer_fill_mode ? 1'b0 :
                           restart ? !buffer_half_status : buffer_half_status;
   wire [3:0]  place_addr = result_dma_enable ? 4'h0 :
                            buffer_fill_mode ? {buffer_half_status, wr_idx[2:0]} : wr_idx;

   // interrupt every rate+1 operations
   // Counter also runs in DMA mode, where it paces dma_step
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         op_cnt   <= 5'h00;
         conv_irq <= 1'b0;
         dma_step <= 1'b0;
      end
      else if (ce)
      begin
         if (done)
            op_cnt <= next_op_cnt;
         conv_irq <= rate_evt && !result_dma_enable;
         dma_step <= rate_evt && result_dma_enable;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_idx             <= 4'h0;
         buffer_half_status <= 1'b0;
      end
      else if (ce)
      begin
         buffer_half_status <= next_half;
         if (done && !result_dma_enable)
            wr_idx <= next_wr_idx;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         buf_wr <= '0;
      else if (ce)
      begin
         buf_wr.en   <= done;
         buf_wr.addr <= place_addr;
         buf_wr.data <= conv_result;
      end
   end

   // multiplexer alternation
   // Toggle on completion so the next sample takes the other set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mux_sel_b <= 1'b0;
      else if (ce)
         mux_sel_b <= alternate_sample_mode && (done ? !mux_sel_b : mux_sel_b);
   end

   // Settings published to the analog core
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clk_cfg <= '0;
      else if (ce)
         clk_cfg <= '{clk_src: conversion_clock_source, samp_time: auto_sample_time,
                      clk_div: conversion_clock_divider};
   end

   asbc_divider #(
      .W (8)
   ) u_div (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .rc_sel    (conversion_clock_source),
      .rc_tick   (rc_tick),
      .div_value (conversion_clock_divider),
      .tick      (conv_tick)
   );

   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_irq_rate: assert property (done && cnt_hit && !result_dma_enable |=> conv_irq)
      else $error("interrupt missing at rate count");
   // A stretched pulse under ce low has no fresh cause behind it
   a_irq_cause: assert property (conv_irq && $past(ce)
                                 |-> $past(conv_done) && $past(op_cnt) >= $past(interrupt_increment_rate))
      else $error("interrupt without rate count");
   a_half_flip: assert property (restart && buffer_fill_mode |=> buffer_half_status != $past(buffer_half_status))
      else $error("buffer half did not alternate");
   a_half_addr: assert property (done && buffer_fill_mode && !result_dma_enable
                                 |=> buf_wr.addr[3] == $past(buffer_half_status))
      else $error("write outside active half");
   a_fill_restart: assert property (restart && !buffer_fill_mode |=> wr_idx == 4'h0 && !buffer_half_status)
      else $error("fill did not restart at start");
   a_alt_toggle: assert property (done && alternate_sample_mode |=> mux_sel_b != $past(mux_sel_b))
      else $error("multiplexer did not alternate");
   a_alt_off: assert property (ce && !alternate_sample_mode |=> !mux_sel_b)
      else $error("multiplexer B used without alternate mode");
   a_dma_addr: assert property (done && result_dma_enable |=> buf_wr.en && buf_wr.addr == 4'h0)
      else $error("dma result not at location zero");
   a_spread_step: assert property (done && !result_dma_enable && !cnt_hit
                                   |=> wr_idx == $past(wr_idx) + 4'h1)
      else $error("buffer index did not advance");

   // Bus answer: ready one cycle after setup, data and error only with it
   a_pready_next: assert property (ce && setup |=> pready)
      else $error("ready missing after setup");
   a_pready_single: assert property (ce && pready && psel && penable |=> !pready)
      else $error("ready held past access");
   a_prdata_idle: assert property (ce && !(setup && !pwrite) |=> prdata == 32'h00000000)
      else $error("read data outside read access");
   a_err_response: assert property (ce && setup && (!mapped || ro_write) |=> pready && pslverr)
      else $error("error response missing");
   a_err_quiet: assert property (ce && setup && mapped && !ro_write |=> !pslverr)
      else $error("error on a legal access");
   a_sts_count: assert property (ce && setup && !pwrite && hit_sts |=> prdata[4:0] == $past(op_cnt))
      else $error("status read lost the count");

   // Register writes land at the access edge only
   a_seq_write: assert property (ce && wr_access && hit_seq |=>
      interrupt_increment_rate == $past(pwdata[`ASBC_SEQ_RATE_MSB:`ASBC_SEQ_RATE_LSB])
      && buffer_fill_mode == $past(pwdata[`ASBC_SEQ_FILL_BIT]))
      else $error("sequence write lost");
   a_clk_write: assert property (ce && wr_access && hit_clk |=>
      conversion_clock_divider == $past(pwdata[`ASBC_CLK_DIV_MSB:`ASBC_CLK_DIV_LSB])
      && conversion_clock_source == $past(pwdata[`ASBC_CLK_SRC_BIT]))
      else $error("clock register write lost");
   a_dma_write: assert property (ce && wr_access && hit_dma |=>
      result_dma_enable == $past(pwdata[`ASBC_DMA_EN_BIT]))
      else $error("dma enable write lost");

   // Freeze: with ce low nothing moves, pulses included
   a_ce_freeze: assert property (!ce |=> $stable(op_cnt) && $stable(wr_idx) && $stable(buf_wr)
                                 && $stable(conv_irq) && $stable(mux_sel_b) && $stable(pready))
      else $error("state moved while clock enable low");

   // Counting and placement
   a_op_step: assert property (done && !cnt_hit |=> op_cnt == $past(op_cnt) + 5'h01)
      else $error("operation count did not advance");
   a_op_wrap: assert property (done && cnt_hit |=> op_cnt == 5'h00)
      else $error("operation count did not wrap");
   a_dma_no_irq: assert property (ce && result_dma_enable |=> !conv_irq)
      else $error("interrupt raised in dma mode");
   a_dma_step: assert property (done && cnt_hit && result_dma_enable |=> dma_step)
      else $error("dma step missing at rate count");
   a_dma_hold: assert property (ce && result_dma_enable |=> $stable(wr_idx))
      else $error("buffer index moved in dma mode");
   a_half_off: assert property (ce && !buffer_fill_mode |=> !buffer_half_status)
      else $error("half status set without fill mode");
   a_spread_addr: assert property (done && !result_dma_enable && !buffer_fill_mode
                                   |=> buf_wr.addr == $past(wr_idx))
      else $error("result not at running index");
   a_fill_addr: assert property (done && buffer_fill_mode && !result_dma_enable
                                 |=> buf_wr.addr[2:0] == $past(wr_idx[2:0]))
      else $error("fill offset lost");
   a_result_data: assert property (done |=> buf_wr.en && buf_wr.data == $past(conv_result))
      else $error("result data not carried");
   a_cfg_copy: assert property (ce |=> clk_cfg.clk_div == $past(conversion_clock_divider)
                                && clk_cfg.clk_src == $past(conversion_clock_source))
      else $error("clock settings not published");

   c_fill_irq: cover property (restart && buffer_fill_mode ##[1:40] restart);
   c_dma_write: cover property (buf_wr.en && result_dma_enable);
   c_alt_pair: cover property (mux_sel_b ##[1:10] !mux_sel_b);
   c_wrap16: cover property (done && wr_idx == 4'hf && !buffer_fill_mode);
endmodule

// ===== dv/asbc_ctrl_tb.sv
// Purpose: Self-checking bench for the sequencing control block
// Assumes: APB slave answers one cycle after setup; conv_done sampled each edge
// Notes:   Resets between scenarios so counters start from a known state
`timescale 1ns/1ps
module asbc_ctrl_tb;
   logic                      pclk, presetn, ce, psel, penable, pwrite;
   logic                      conv_done, rc_tick, pready, pslverr;
   logic                      mux_sel_b, conv_irq, dma_step, buffer_half_status, conv_tick;
   logic [7:0]                paddr;
   logic [31:0]               pwdata, prdata;
   logic [15:0]               conv_result;
   asbc_pkg::asbc_buf_write_t buf_wr;
   asbc_pkg::asbc_clk_cfg_t   clk_cfg;
   int                        errors, samples_checked, n;
   int                        rates [4] = '{0, 1, 2, 16};
   int                        divs [5]  = '{0, 1, 3, 4, 9};

   asbc_ctrl DUT (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
      .conv_result(conv_result), .rc_tick(rc_tick), .buf_wr(buf_wr),
      .mux_sel_b(mux_sel_b), .conv_irq(conv_irq), .dma_step(dma_step),
      .buffer_half_status(buffer_half_status), .conv_tick(conv_tick), .clk_cfg(clk_cfg)
   );

   initial
   begin
      pclk = 1'h0;
      forever #2 pclk = ~pclk;
   end

   task automatic close_out;
      $display("Comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic do_reset;
      presetn <= 1'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] er, input logic ee);
      int i;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge pclk);
         if (pready === 1'h1)
            break;
      end
      if (i == 20)
      begin
         errors++;
         close_out();
      end
      if (w === 1'h0)
         chk("prdata", er, prdata);
      chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // One completed operation, result seen one cycle later
   task automatic conv(input logic [15:0] v, input logic [3:0] a, input logic i,
                       input logic d, input logic m);
      @(posedge pclk);
      conv_done <= 1'h1;
      conv_result <= v;
      @(posedge pclk);
      conv_done <= 1'h0;
      #1;
      chk("buf_wr", {11'h0, 1'h1, a, v}, {11'h0, buf_wr});
      chk("irq_dma_mux", {29'h0, i, d, m}, {29'h0, conv_irq, dma_step, mux_sel_b});
   endtask

   initial
   begin
      repeat (100000) @(posedge pclk);
      errors++;
      close_out();
   end

   initial
   begin
      errors = 0;
      samples_checked = 0;
      {ce, psel, penable, pwrite, conv_done, rc_tick, presetn} = 7'h40;
      paddr = 8'h00;
      pwdata = 32'h0;
      conv_result = 16'h0;
      do_reset();
      apb(1'h0, 8'h00, 32'h0, 32'h0, 1'h0);
      apb(1'h0, 8'h04, 32'h0, 32'h0, 1'h0);
      apb(1'h0, 8'h08, 32'h0, 32'h0, 1'h0);
      apb(1'h0, 8'h0c, 32'h0, 32'h0, 1'h0);
      apb(1'h0, 8'h10, 32'h0, 32'h0, 1'h1);
      apb(1'h1, 8'h0c, 32'h0000_0fff, 32'h0, 1'h1);
      // Half status bit is read-only
      apb(1'h1, 8'h00, 32'h0000_00ff, 32'h0, 1'h0);
      apb(1'h0, 8'h00, 32'h0, 32'h0000_007f, 1'h0);
      apb(1'h1, 8'h04, 32'h0000_8c05, 32'h0, 1'h0);
      apb(1'h0, 8'h04, 32'h0, 32'h0000_8c05, 1'h0);
      chk("clk_cfg", {18'h0, 1'h1, 5'h0c, 8'h05}, {18'h0, clk_cfg});
      n = 0;
      for (int j = 0; j < 20; j++)
      begin
         @(posedge pclk);
         rc_tick <= (j % 5 == 0);
         n += (conv_tick === 1'h1);
      end
      chk("rc_ticks", 32'h4, n);
      foreach (divs[q])
      begin
         apb(1'h1, 8'h04, {24'h0, 8'(divs[q])}, 32'h0, 1'h0);
         repeat (8) @(posedge pclk);
         n = 0;
         repeat (40) @(posedge pclk) n += (conv_tick === 1'h1);
         chk("div_ticks", 40 / (divs[q] + 1), n);
      end
      foreach (rates[r])
      begin
         do_reset();
         apb(1'h1, 8'h00, rates[r] << 2, 32'h0, 1'h0);
         for (int k = 0; k < 2 * (rates[r] + 1); k++)
            conv(16'ha000 + k, 4'((k % (rates[r] + 1)) % 16),
                 k % (rates[r] + 1) == rates[r], 1'h0, 1'h0);
      end
      do_reset();
      apb(1'h1, 8'h00, 32'h0000_0007, 32'h0, 1'h0);
      for (int k = 0; k < 8; k++)
      begin
         conv(16'hb000 + k, {1'((k / 2) % 2), 3'(k % 2)}, 1'(k % 2), 1'h0, 1'((k + 1) % 2));
         chk("half", ((k + 1) / 2) % 2, {31'h0, buffer_half_status});
      end
      // Results pinned to location zero, interrupt withheld
      do_reset();
      apb(1'h1, 8'h08, 32'h0000_0100, 32'h0, 1'h0);
      apb(1'h1, 8'h00, 32'h0000_0004, 32'h0, 1'h0);
      for (int k = 0; k < 4; k++)
         conv(16'hc000 + k, 4'h0, 1'h0, 1'(k % 2), 1'h0);
      // Clock enable low: completions must leave no trace
      @(posedge pclk);
      ce <= 1'h0;
      conv_done <= 1'h1;
      repeat (3) @(posedge pclk);
      chk("frozen_buf_wr", 32'h0, {31'h0, buf_wr.en});
      ce <= 1'h1;
      conv_done <= 1'h0;
      apb(1'h0, 8'h0c, 32'h0, 32'h0, 1'h0);
      close_out();
   end
endmodule
